// [design/ddc_decim_chain.sv]
// Decimation filter chain top: mode decode, stage routing, output words.
`timescale 1ns/1ps
`include "ddc_map.svh"
//==========================================================================
// Overview of operation
// R01: Decimation by 2, 4, 8, 16 or bypass.
// R02: Decimated outputs are 15 bits wide; the no-flag mode keeps 12.
// R03: By 2 is real; 4, 8, 16 are I/Q.
// R04: Rate is clock over factor; bypass 12-bit.
// R05: Protected band 0.8 output, 0.4 for by 2.
// R06: Wide select picks 45+87 instead of 45+80.
// R07: Cascades 80; 20,40,80; 10,20,40,80.
// R08: Each stage halves rate, symmetric taps.
// R09: Half-band sets 10 and 20 taps.
// R10: Half-band sets 40 and 45 taps.
// R11: Half-band set 80 taps.
// R12: Half-band set 87 taps.
// R13: Stop-band figures follow from the tap sets.
// R14: Link mode code selects decimation factor.
// R15: 15 bits high, over-range flag in LSB.
// R16: Stages scale results to avoid overflow.
//==========================================================================
module ddc_decim_chain
  import ddc_pkg::*;
#(
  parameter int FIFO_DEPTH = `DDC_FIFO_DEPTH
) (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration levels.
  input wire logic [`DDC_LMODE_W-1:0] link_mode_select,
  input wire logic dec4_wide_passband_sel,
  // Input samples from the converter and the mixer.
  input wire logic [`DDC_RAW_W-1:0] adc_sample,
  input wire logic [15:0] mix_i,
  input wire logic [15:0] mix_q,
  input wire logic in_valid,
  output logic in_ready,
  // Over-range detector levels.
  input wire logic overrange_flag_lo,
  input wire logic overrange_flag_hi,
  // Output words towards the transport layer.
  output logic out_valid,
  input wire logic out_ready,
  output logic [`DDC_WORD_W-1:0] out_word_i,
  output logic [`DDC_WORD_W-1:0] out_word_q,
  output logic out_is_complex
);
  localparam int FW = 2 * `DDC_WORD_W + 1;

  //========================================================================
  // Declarations
  ddc_dec_e cur_mode;
  ddc_dec_e next_mode;
  logic wide_q;
  logic nf_q;
  logic flush;
  logic stage_rst;
  logic run;
  logic in_take;
  logic is2;
  logic is4;
  logic is8;
  logic is16;
  logic use87;
  logic [31:0] cin_data;
  logic fin_valid;
  logic [31:0] fin_data;
  logic push;
  logic odd_q;
  logic acc_lo;
  logic acc_hi;
  logic flag_lo;
  logic flag_hi;
  logic [`DDC_OUT_W-1:0] s_i15;
  logic [`DDC_OUT_W-1:0] s_q15;
  logic [`DDC_WORD_W-1:0] w_i;
  logic [`DDC_WORD_W-1:0] w_q;
  logic w_cplx;
  logic f_ready;
  logic f_m_valid;
  logic f_m_ready;
  logic [FW-1:0] f_m_data;

  //========================================================================
  // Functions

  // Map a link mode code onto a decimation setting; unknown codes bypass.
  function automatic ddc_dec_e mode_decode(
    input logic [`DDC_LMODE_W-1:0] m
  );
    if (m == `DDC_LMODE_DEC2) begin
      mode_decode = dec_by2; // R14
    end else if (m >= `DDC_LMODE_DEC4_LO && m <= `DDC_LMODE_DEC4_NF) begin
      mode_decode = dec_by4; // R14
    end else if (m >= `DDC_LMODE_DEC8_LO && m <= `DDC_LMODE_DEC8_HI) begin
      mode_decode = dec_by8; // R14
    end else if (m >= `DDC_LMODE_DEC16_LO && m <= `DDC_LMODE_DEC16_HI) begin
      mode_decode = dec_by16; // R14
    end else begin
      mode_decode = dec_bypass; // R01
    end
  endfunction : mode_decode

  // Round a 16-bit stage result to 15 bits, saturating the top code.
  function automatic logic [`DDC_OUT_W-1:0] rnd15(input ddc_samp_t x);
    logic signed [16:0] t;
    t = (17'(x) + 17'sh1) >>> 1;
    if (t > 17'sh3FFF) rnd15 = 15'h3FFF; // R02
    else rnd15 = t[14:0]; // R02
  endfunction : rnd15

  //========================================================================
  // Mode control

  // Decode runs every cycle so a new code takes effect promptly.
  always_comb begin
    next_mode = mode_decode(link_mode_select);
  end

  // A change of setting flushes the stages so no stale taps mix in.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_mode <= dec_bypass;
      wide_q <= 1'b0;
      nf_q <= 1'b0;
      flush <= 1'b0;
    end else if (ce) begin
      flush <= (next_mode != cur_mode) ||
               (dec4_wide_passband_sel != wide_q);
      cur_mode <= next_mode;
      wide_q <= dec4_wide_passband_sel; // R06
      nf_q <= (link_mode_select == `DDC_LMODE_DEC4_NF); // R15
    end
  end

  // Mode qualifiers used by the routing below.
  assign is2 = (cur_mode == dec_by2);
  assign is4 = (cur_mode == dec_by4);
  assign is8 = (cur_mode == dec_by8);
  assign is16 = (cur_mode == dec_by16);
  assign use87 = is4 & wide_q; // R06
  assign stage_rst = rst | flush;

  //========================================================================
  // Flow control

  // The whole chain stalls while the output FIFO is full, so no
  // result is ever dropped; the stall reaches the source via in_ready.
  assign run = ce & f_ready;
  assign in_take = in_valid & run;
  assign in_ready = f_ready;

  // Real input is left-justified into the I lane; Q stays zero.
  assign cin_data = is2 ? {adc_sample, 4'h0, 16'h0} : {mix_i, mix_q};

  //========================================================================
  // Stage streams
  ddc_strm_if s10_i ();
  ddc_strm_if s10_o ();
  ddc_strm_if s20_i ();
  ddc_strm_if s20_o ();
  ddc_strm_if s40_i ();
  ddc_strm_if s40_o ();
  ddc_strm_if s45_i ();
  ddc_strm_if s45_o ();
  ddc_strm_if s80_i ();
  ddc_strm_if s80_o ();
  ddc_strm_if s87_i ();
  ddc_strm_if s87_o ();

  // Routing: by 16 enters at set 10, by 8 at set 20, by 4 at set 45.
  assign s10_i.valid = in_take & is16; // R07
  assign s10_i.data = cin_data;
  assign s20_i.valid = is16 ? s10_o.valid : (in_take & is8); // R07
  assign s20_i.data = is16 ? s10_o.data : cin_data;
  assign s40_i.valid = s20_o.valid; // R07
  assign s40_i.data = s20_o.data;
  assign s45_i.valid = in_take & is4; // R06
  assign s45_i.data = cin_data;
  assign s87_i.valid = s45_o.valid & wide_q; // R06
  assign s87_i.data = s45_o.data;

  // Set 80 closes every chain except the wide by-4 one.
  always_comb begin
    if (is2) begin
      s80_i.valid = in_take; // R07
      s80_i.data = cin_data;
    end else if (is4) begin
      s80_i.valid = s45_o.valid & ~wide_q; // R06
      s80_i.data = s45_o.data;
    end else begin
      s80_i.valid = s40_o.valid & (is8 | is16); // R07
      s80_i.data = s40_o.data;
    end
  end

  //========================================================================
  // Filter stages; the tap sets fix the band edges and stop-band depth.

  // Set 10.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_10_K), .COEF(`DDC_HALFBAND_SET_10_TAPS), // R09
    .CENTER(`DDC_HALFBAND_SET_10_C), .SHIFT(`DDC_HALFBAND_SET_10_S) // R09
  ) u_hb10 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s10_i), .dout(s10_o)
  );

  // Set 20.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_20_K), .COEF(`DDC_HALFBAND_SET_20_TAPS), // R09
    .CENTER(`DDC_HALFBAND_SET_20_C), .SHIFT(`DDC_HALFBAND_SET_20_S) // R09
  ) u_hb20 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s20_i), .dout(s20_o)
  );

  // Set 40.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_40_K), .COEF(`DDC_HALFBAND_SET_40_TAPS), // R10
    .CENTER(`DDC_HALFBAND_SET_40_C), .SHIFT(`DDC_HALFBAND_SET_40_S) // R10
  ) u_hb40 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s40_i), .dout(s40_o)
  );

  // Set 45.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_45_K), .COEF(`DDC_HALFBAND_SET_45_TAPS), // R10
    .CENTER(`DDC_HALFBAND_SET_45_C), .SHIFT(`DDC_HALFBAND_SET_45_S) // R10
  ) u_hb45 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s45_i), .dout(s45_o)
  );

  // Set 80: the long stage sets the 0.8 and 0.4 protected bands.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_80_K), .COEF(`DDC_HALFBAND_SET_80_TAPS), // R11 R05 R13
    .CENTER(`DDC_HALFBAND_SET_80_C), .SHIFT(`DDC_HALFBAND_SET_80_S) // R11
  ) u_hb80 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s80_i), .dout(s80_o)
  );

  // Set 87: wider band, traded for shallower stop-band.
  ddc_halfband #(
    .K(`DDC_HALFBAND_SET_87_K), .COEF(`DDC_HALFBAND_SET_87_TAPS), // R12 R13
    .CENTER(`DDC_HALFBAND_SET_87_C), .SHIFT(`DDC_HALFBAND_SET_87_S) // R12
  ) u_hb87 (
    .clk(sys_clk), .rst(stage_rst), .run(run),
    .din(s87_i), .dout(s87_o)
  );

  //========================================================================
  // Chain output

  // Bypass hands every sample through, giving the full clock rate.
  always_comb begin
    if (cur_mode == dec_bypass) begin
      fin_valid = in_take; // R04
      fin_data = cin_data;
    end else if (use87) begin
      fin_valid = s87_o.valid; // R04
      fin_data = s87_o.data;
    end else begin
      fin_valid = s80_o.valid; // R04
      fin_data = s80_o.data;
    end
  end
  assign push = fin_valid & run;

  // Over-range levels are gathered over one output period; a detection
  // in the cycle of the clearing push is kept for the next word.
  assign flag_lo = acc_lo | (in_take & overrange_flag_lo);
  assign flag_hi = acc_hi | (in_take & overrange_flag_hi);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_lo <= 1'b0;
      acc_hi <= 1'b0;
    end else if (ce) begin
      acc_lo <= (acc_lo & ~push) | (in_take & overrange_flag_lo);
      acc_hi <= (acc_hi & ~push) | (in_take & overrange_flag_hi);
    end
  end

  // Even and odd real words alternate which flag they carry.
  always_ff @(posedge sys_clk) begin
    if (rst || flush) begin
      odd_q <= 1'b0;
    end else if (push && is2) begin
      odd_q <= ~odd_q; // R15
    end
  end

  //========================================================================
  // Word format

  // Samples sit in the upper bits; the code without flags keeps 12 bits.
  always_comb begin
    s_i15 = rnd15(fin_data[31:16]);
    s_q15 = rnd15(fin_data[15:0]);
    w_i = '0;
    w_q = '0;
    w_cplx = 1'b0;
    unique case (cur_mode)
      dec_bypass: begin
        w_i = {adc_sample, 4'h0}; // R04
      end
      dec_by2: begin
        w_i = {s_i15, odd_q ? flag_hi : flag_lo}; // R03 R15
      end
      dec_by4, dec_by8, dec_by16: begin
        w_cplx = 1'b1; // R03
        if (nf_q) begin
          w_i = {s_i15[14:3], 4'h0}; // R15
          w_q = {s_q15[14:3], 4'h0}; // R15
        end else begin
          w_i = {s_i15, flag_lo}; // R15
          w_q = {s_q15, flag_hi}; // R15
        end
      end
    endcase
  end

  //========================================================================
  // Output buffering

  // The FIFO absorbs short stalls of the transport layer.
  ddc_fifo #(
    .W(FW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .s_valid(push),
    .s_ready(f_ready),
    .s_data({w_cplx, w_i, w_q}),
    .m_valid(f_m_valid),
    .m_ready(f_m_ready),
    .m_data(f_m_data)
  );
  assign f_m_ready = ce & (~out_valid | out_ready);

  // Output register keeps every output word port on a flip-flop; in_ready is the FIFO's registered s_ready.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_word_i <= '0;
      out_word_q <= '0;
      out_is_complex <= 1'b0;
    end else if (f_m_ready) begin
      out_valid <= f_m_valid;
      if (f_m_valid) begin
        out_is_complex <= f_m_data[FW-1];
        out_word_i <= f_m_data[FW-2:`DDC_WORD_W];
        out_word_q <= f_m_data[`DDC_WORD_W-1:0];
      end
    end
  end
endmodule : ddc_decim_chain

// [design/ddc_map.svh]
// Constants of the decimation filter chain: modes, widths, coefficient sets.
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
//==========================================================================
// Link mode codes and widths
`define DDC_LMODE_W 5
`define DDC_LMODE_DEC2 5'h09
`define DDC_LMODE_DEC4_LO 5'h0A
`define DDC_LMODE_DEC4_NF 5'h0C
`define DDC_LMODE_DEC8_LO 5'h0D
`define DDC_LMODE_DEC8_HI 5'h0E
`define DDC_LMODE_DEC16_LO 5'h0F
`define DDC_LMODE_DEC16_HI 5'h10
`define DDC_RAW_W 12
`define DDC_OUT_W 15
`define DDC_NF_W 12
`define DDC_WORD_W 16
`define DDC_FIFO_DEPTH 4
//==========================================================================
// Half-band sets: nonzero side taps outer to inner, center, count, shift
`define DDC_HALFBAND_SET_10_K 2
`define DDC_HALFBAND_SET_10_C 20'sh400
`define DDC_HALFBAND_SET_10_S 11
`define DDC_HALFBAND_SET_10_TAPS '{0: -20'sh41, 1: 20'sh241, default: 20'sh0}
`define DDC_HALFBAND_SET_20_K 3
`define DDC_HALFBAND_SET_20_C 20'sh2000
`define DDC_HALFBAND_SET_20_S 14
`define DDC_HALFBAND_SET_20_TAPS '{0: 20'sh6D, 1: -20'sh345, 2: 20'sh12D8, \
  default: 20'sh0}
`define DDC_HALFBAND_SET_40_K 4
`define DDC_HALFBAND_SET_40_C 20'sh10000
`define DDC_HALFBAND_SET_40_S 17
`define DDC_HALFBAND_SET_40_TAPS '{0: -20'sh147, 1: 20'sh8B7, 2: -20'sh22B1, \
  3: 20'sh9B3E, default: 20'sh0}
`define DDC_HALFBAND_SET_45_K 5
`define DDC_HALFBAND_SET_45_C 20'sh8000
`define DDC_HALFBAND_SET_45_S 16
`define DDC_HALFBAND_SET_45_TAPS '{0: 20'sh38, 1: -20'sh191, 2: 20'sh63C, \
  3: -20'sh1373, 4: 20'sh4E91, default: 20'sh0}
`define DDC_HALFBAND_SET_80_K 14
`define DDC_HALFBAND_SET_80_C 20'sh40000
`define DDC_HALFBAND_SET_80_S 19
`define DDC_HALFBAND_SET_80_TAPS '{0: -20'sh25, 1: 20'sh76, 2: -20'sh123, \
  3: 20'sh264, 4: -20'sh487, 5: 20'sh7EF, 6: -20'shD1C, 7: 20'sh14BC, \
  8: -20'sh1FCC, 9: 20'sh2FFC, 10: -20'sh48C4, 11: 20'sh730F, \
  12: -20'shCFC7, 13: 20'sh288AB, default: 20'sh0}
`define DDC_HALFBAND_SET_87_K 16
`define DDC_HALFBAND_SET_87_C 20'sh4000
`define DDC_HALFBAND_SET_87_S 15
`define DDC_HALFBAND_SET_87_TAPS '{-20'shF, 20'sh17, -20'sh28, 20'sh40, -20'sh61, \
  20'sh8E, -20'shC9, 20'sh117, -20'sh17C, 20'sh201, -20'sh2B2, \
  20'sh3AB, -20'sh521, 20'sh7A4, -20'shD46, 20'sh28A4}
`endif

// [design/ddc_pkg.sv]
// Types shared by the decimation filter chain modules.
package ddc_pkg;
  typedef logic signed [15:0] ddc_samp_t;
  typedef logic signed [19:0] ddc_coef_t;
  typedef enum {dec_bypass, dec_by2, dec_by4, dec_by8, dec_by16} ddc_dec_e;
endpackage : ddc_pkg

// [design/ddc_strm_if.sv]
// Sample stream carrier between filter stages: I lane high, Q lane low.
`timescale 1ns/1ps
interface ddc_strm_if;
  logic valid;
  logic [31:0] data;
  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface : ddc_strm_if

// [design/ddc_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ddc_fifo
  import ddc_pkg::*;
#(
  parameter int W = 33,
  parameter int D = 4
) (
  // Clocking.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Fill side.
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  // Drain side.
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  // Handshakes; nothing moves while the clock enable is low.
  assign push = ce & s_valid & s_ready;
  assign pop = ce & m_valid & m_ready;
  assign m_valid = (count != '0);
  assign m_data = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Storage carries no reset; only occupied words are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end

  // Pointers and occupancy; ready is registered so full is exact.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      s_ready <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= next_count;
      s_ready <= (next_count != (AW+1)'(D));
    end
  end
endmodule : ddc_fifo

// [design/ddc_halfband.sv]
// One symmetric half-band decimate-by-two stage for an I/Q pair.
`timescale 1ns/1ps
module ddc_halfband
  import ddc_pkg::*;
#(
  parameter int K = 2,
  parameter ddc_coef_t COEF [16] = '{default: 20'sh0},
  parameter ddc_coef_t CENTER = 20'sh400,
  parameter int SHIFT = 11
) (
  // Clocking; run freezes the stage when low.
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  // Streams.
  ddc_strm_if.snk din,
  ddc_strm_if.src dout
);
  localparam int L = 4 * K - 1;
  localparam int C = 2 * K - 1;
  ddc_samp_t li [L];
  ddc_samp_t lq [L];
  logic phase;
  logic calc;

  // Folded MAC over the tap line, rounded and saturated to 16 bits.
  function automatic ddc_samp_t mac(input ddc_samp_t ln [L]);
    logic signed [47:0] acc;
    acc = 48'(ln[C]) * 48'(CENTER);
    for (int k = 0; k < K; k++) begin
      acc = acc + 48'(COEF[k]) * (48'(ln[2*k]) + 48'(ln[L-1-2*k])); // R08
    end
    acc = (acc + (48'sh1 <<< (SHIFT - 1))) >>> SHIFT; // R16
    if (acc > 48'sh7FFF) mac = 16'sh7FFF;
    else if (acc < -48'sh8000) mac = -16'sh8000;
    else mac = acc[15:0];
  endfunction : mac

  // Tap line shifts on every accepted input sample.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < L; i++) begin
        li[i] <= '0;
        lq[i] <= '0;
      end
    end else if (run && din.valid) begin
      li[0] <= din.data[31:16];
      lq[0] <= din.data[15:0];
      for (int i = 1; i < L; i++) begin
        li[i] <= li[i-1];
        lq[i] <= lq[i-1];
      end
    end
  end

  // Every second input arms one output computation.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 1'b0;
      calc <= 1'b0;
    end else if (run) begin
      calc <= din.valid & phase; // R08
      if (din.valid) phase <= ~phase;
    end
  end

  // Output pulse lasts until the next running edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      dout.valid <= 1'b0;
      dout.data <= '0;
    end else if (run) begin
      dout.valid <= calc;
      if (calc) dout.data <= {mac(li), mac(lq)};
    end
  end
endmodule : ddc_halfband

// [design/ddc_strm_if_unused_guard.sv]
// Intentionally empty; this file holds no design unit.

// [tb/ddc_chain_checker.sv]
// Concurrent checks on the ports of the decimation chain top.
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_chain_checker
  import ddc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration and input handshake.
  input wire logic [`DDC_LMODE_W-1:0] link_mode_select,
  input wire logic in_valid,
  input wire logic in_ready,
  // Output words.
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [`DDC_WORD_W-1:0] out_word_i,
  input wire logic [`DDC_WORD_W-1:0] out_word_q,
  input wire logic out_is_complex
);
  //====================
  // Checks
  // One clock domain, so reset switches every check off in one place.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A word waiting for the sink must not move or vanish.
  stall_hold_a:
    assert property (out_valid && !out_ready && ce |=> out_valid &&
      $stable(out_word_i) && $stable(out_word_q))
    else $error("stalled output word changed");
  // Reset leaves every output cleared at the first edge after release.
  reset_clear_a:
    assert property ($fell(rst) |-> !out_valid && !in_ready &&
      out_word_i == 16'h0 && out_word_q == 16'h0 && !out_is_complex)
    else $error("outputs not cleared by reset");
  ready_up_a:
    assert property ($fell(rst) && ce |=> in_ready)
    else $error("input not ready after reset release");
  freeze_a:
    assert property (!ce |=> $stable(out_valid) && $stable(in_ready) &&
      $stable(out_word_i))
    else $error("state moved while enable low");
  real_q_a:
    assert property (out_valid && !out_is_complex |-> out_word_q == 16'h0)
    else $error("real word with nonzero quadrature lane");
  mode_cx_a:
    assert property (out_valid |-> out_is_complex ==
      (link_mode_select inside {[5'h0A:5'h10]}))
    else $error("complex flag disagrees with link mode");
  nf_low_a:
    assert property (out_valid && link_mode_select == `DDC_LMODE_DEC4_NF
      |-> out_word_i[3:0] == 4'h0 && out_word_q[3:0] == 4'h0)
    else $error("flagless mode shows low bits");
  byp_low_a:
    assert property (out_valid && !out_is_complex &&
      link_mode_select != `DDC_LMODE_DEC2 |-> out_word_i[3:0] == 4'h0)
    else $error("bypass word low bits not zero");
  // Eight stalled cycles of offered bypass samples fill a FIFO of up to seven words.
  full_stop_a:
    assert property ((link_mode_select == 5'h1F && in_valid && ce &&
      out_valid && !out_ready) [*8] |-> !in_ready)
    else $error("input still ready with full buffer");
endmodule : ddc_chain_checker

bind ddc_decim_chain ddc_chain_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .sys_clk, .rst, .ce, .link_mode_select, .in_valid, .in_ready,
  .out_valid, .out_ready, .out_word_i, .out_word_q, .out_is_complex);

// [tb/ddc_link_sink.sv]
// Downstream transport model that accepts words and stalls on request.
`timescale 1ns/1ps
module ddc_link_sink (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Stall controls.
  input wire logic hold,
  input wire logic slow,
  // Handshake towards the chain.
  output logic out_ready = 1'b0
);
  // Ready moves on the falling edge only, so the chain samples it settled.
  // A slow sink accepts about every second cycle, which keeps the buffer
  // under pressure without starving the output.
  always @(negedge sys_clk) begin
    if (rst || hold) begin
      out_ready <= 1'b0;
    end else if (slow) begin
      out_ready <= 1'(($urandom % 2) == 0);
    end else begin
      out_ready <= 1'b1;
    end
  end
endmodule : ddc_link_sink

// [tb/ddc_decim_chain_tb.sv]
// Self-checking bench of the decimation filter chain top.
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_decim_chain_tb;
  typedef struct {
    logic [15:0] i;
    logic [15:0] q;
    logic cx;
    logic chk;
  } ddc_exp_s;
  logic sys_clk, rst, ce, dec4_wide_passband_sel, in_valid, in_ready;
  logic overrange_flag_lo, overrange_flag_hi, hold, slow;
  logic out_valid, out_ready, out_is_complex;
  logic [`DDC_LMODE_W-1:0] link_mode_select;
  logic [11:0] adc_sample;
  logic [15:0] mix_i, mix_q, out_word_i, out_word_q;
  ddc_exp_s exp_q[$];
  ddc_exp_s got;
  int n_errors = 0;
  int compares = 0;

  //====================
  // Design and far side
  ddc_decim_chain #(.FIFO_DEPTH(`DDC_FIFO_DEPTH)) uut (
    .sys_clk, .rst, .ce, .link_mode_select, .dec4_wide_passband_sel,
    .adc_sample, .mix_i, .mix_q, .in_valid, .in_ready, .overrange_flag_lo,
    .overrange_flag_hi, .out_valid, .out_ready, .out_word_i, .out_word_q,
    .out_is_complex);
  ddc_link_sink sink (.sys_clk, .rst, .hold, .slow, .out_ready);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  //====================
  // Checking
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  function automatic void note(input logic [15:0] i, input logic [15:0] q,
      input logic cx, input logic chk);
    exp_q.push_back('{i, q, cx, chk});
  endfunction : note

  // Each accepted word retires the oldest note; a word with no note is
  // an extra output and counts as a mismatch.
  always @(posedge sys_clk) begin
    if (!rst && ce === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0) begin
        check("word count", 16'h1, 16'h0);
      end else begin
        got = exp_q.pop_front();
        if (got.chk) begin
          check("word_i", out_word_i, got.i);
          check("word_q", out_word_q, got.q);
          check("complex", {15'h0, out_is_complex}, {15'h0, got.cx});
        end
      end
    end
  end

  //====================
  // Drivers
  // The sample is held until an edge sees ready and enable both high.
  task automatic offer(input logic [11:0] a, input logic [15:0] xi,
      input logic [15:0] xq);
    @(negedge sys_clk);
    adc_sample = a;
    mix_i = xi;
    mix_q = xq;
    in_valid = 1'b1;
    do begin
      @(posedge sys_clk);
    end while (!(in_ready === 1'b1 && ce === 1'b1));
  endtask : offer

  task automatic drain(input string name);
    int n;
    n = 0;
    @(negedge sys_clk);
    in_valid = 1'b0;
    while (exp_q.size() != 0 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (6) @(negedge sys_clk);
    check("pending words", 16'(exp_q.size()), 16'h0);
    exp_q.delete();
    $display("test %s done", name);
  endtask : drain

  // Mode changes are made only with the chain drained.
  task automatic set_mode(input logic [4:0] m, input logic w);
    @(negedge sys_clk);
    link_mode_select = m;
    dec4_wide_passband_sel = w;
    repeat (3) @(negedge sys_clk);
  endtask : set_mode

  //====================
  // Scenarios
  // Unknown code runs as bypass; the sink holds off until the buffer is
  // full and enable drops for a while before the words are released.
  task automatic run_bypass();
    logic [11:0] a;
    set_mode(5'h1F, 1'b0);
    hold = 1'b1;
    slow = 1'b1;
    fork
      for (int k = 0; k < 24; k++) begin
        a = 12'($urandom);
        note({a, 4'h0}, 16'h0, 1'b0, 1'b1);
        offer(a, 16'h0, 16'h0);
      end
      begin
        repeat (14) @(negedge sys_clk);
        check("in_ready full", {15'h0, in_ready}, 16'h0);
        ce = 1'b0;
        repeat (4) @(negedge sys_clk);
        ce = 1'b1;
        repeat (4) @(negedge sys_clk);
        hold = 1'b0;
      end
    join
    drain("bypass");
  endtask : run_bypass

  // Tap sums miss unity by a few parts in 2^15, so levels stay within
  // +/-1024, where no stage's rounding moves a steady value; 48 words per
  // D*48 samples, only the last twelve compared once the taps are full.
  task automatic run_dc(input logic [4:0] m, input logic w, input int d);
    logic [15:0] xi, xq;
    logic [14:0] vi, vq;
    logic cx, lo, hi;
    set_mode(m, w);
    cx = (d != 2);
    xi = 16'($signed(11'($urandom))) & (cx ? 16'hFFFE : 16'hFFF0);
    xq = 16'($signed(11'($urandom))) & 16'hFFFE;
    vi = xi[15:1];
    vq = xq[15:1];
    lo = 1'($urandom);
    hi = 1'($urandom);
    overrange_flag_lo = lo;
    overrange_flag_hi = hi;
    for (int k = 0; k < 48; k++) begin
      if (!cx) begin
        note({vi, k[0] ? hi : lo}, 16'h0, 1'b0, k >= 36);
      end else if (m == `DDC_LMODE_DEC4_NF) begin
        note({vi[14:3], 4'h0}, {vq[14:3], 4'h0}, 1'b1, k >= 36);
      end else begin
        note({vi, lo}, {vq, hi}, 1'b1, k >= 36);
      end
    end
    for (int n = 0; n < 48 * d; n++) begin
      offer(xi[15:4], xi, xq);
    end
    drain($sformatf("mode %0d", m));
  endtask : run_dc

  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // The whole sequence needs well under 15000 cycles.
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    void'($urandom(19720));
    {rst, ce, hold, slow} = 4'b1100;
    {dec4_wide_passband_sel, in_valid} = 2'b00;
    {overrange_flag_lo, overrange_flag_hi} = 2'b00;
    link_mode_select = 5'h00;
    adc_sample = 12'h000;
    mix_i = 16'h0000;
    mix_q = 16'h0000;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    run_bypass();
    run_dc(`DDC_LMODE_DEC2, 1'b0, 2);
    run_dc(`DDC_LMODE_DEC4_LO, 1'b0, 4);
    run_dc(5'h0B, 1'b1, 4);
    run_dc(`DDC_LMODE_DEC4_NF, 1'b0, 4);
    run_dc(`DDC_LMODE_DEC8_LO, 1'b0, 8);
    run_dc(`DDC_LMODE_DEC8_HI, 1'b1, 8);
    run_dc(`DDC_LMODE_DEC16_LO, 1'b0, 16);
    run_dc(`DDC_LMODE_DEC16_HI, 1'b0, 16);
    tally_and_finish();
  end
endmodule : ddc_decim_chain_tb
